// file: dv/dc_sync_pulse_output_unit_test.sv
`timescale 1ns/1ps
module dc_sync_pulse_output_unit_test;
	localparam logic [63:0] step  = 64'h0000_0000_0000_000a;
	localparam logic [63:0] slack = 64'h0000_0000_0000_0028;
	logic                   clock;
	logic                   rst;
	logic [63:0]            system_time;
	sync_out_pkg::reg_req_t net_req;
	sync_out_pkg::reg_req_t host_req;
	logic                   frame_end;
	logic                   write_ack_enable;
	logic                   nv_load;
	logic [15:0]            nv_addr;
	logic [15:0]            nv_data;
	logic [7:0]             net_rdata;
	logic [7:0]             host_rdata;
	logic                   first_sync_pulse;
	logic                   second_sync_pulse;
	logic                   first_event_clear;
	logic                   second_event_clear;
	logic [1:0]             outs;
	int                     err_total;
	int                     total_checks;
	int                     cycles;
	int                     rises [2];
	int                     run [2];
	int                     width [2];
	int                     clears [2];
	int                     n;
	int                     k;
	logic [7:0]             seed;
	logic [63:0]            now;
	logic [63:0]            start;
	logic [63:0]            t1;
	logic [63:0]            t2;
	logic [63:0]            t3;
	logic [63:0]            v;
	logic [11:0]            offs [7] = '{sync_out_pkg::activation_off,
		sync_out_pkg::pulse_length_off, sync_out_pkg::activation_status_off,
		sync_out_pkg::first_status_off, sync_out_pkg::second_status_off,
		sync_out_pkg::start_time_off, sync_out_pkg::next_second_off};
	int                     lens [7] = '{1, 2, 1, 1, 1, 8, 8};

	assign outs = {second_sync_pulse, first_sync_pulse};

	sync_output_unit #(.unit_cycles(1)) u_dut (.clock(clock), .rst(rst),
		.system_time(system_time), .net_req(net_req), .host_req(host_req),
		.frame_end(frame_end), .write_ack_enable(write_ack_enable), .nv_load(nv_load),
		.nv_addr(nv_addr), .nv_data(nv_data), .net_rdata(net_rdata),
		.host_rdata(host_rdata), .first_sync_pulse(first_sync_pulse),
		.second_sync_pulse(second_sync_pulse), .first_event_clear(first_event_clear),
		.second_event_clear(second_event_clear));
	reg_port_model u_net (.clock(clock), .rdata(net_rdata), .req(net_req));
	reg_port_model u_host (.clock(clock), .rdata(host_rdata), .req(host_req));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	////////////////////////////////////////////////////////////////////////////////
	// time base, pulse monitor and hang guard
	always @(posedge clock) begin
		system_time <= system_time + step;
		for (int c = 0; c < 2; c++) begin
			if (outs[c] === 1'b1) begin
				if (run[c] == 0) rises[c]++;
				run[c]++;
			end else if (run[c] != 0) begin
				width[c] = run[c];
				run[c] = 0;
			end
		end
		clears[0] += int'(first_event_clear === 1'b1);
		clears[1] += int'(second_event_clear === 1'b1);
		cycles++;
		if (cycles == 40000) begin
			err_total++;
			results();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	// upper half follows the current time, one more if the low half already passed
	function automatic logic [63:0] extend(input logic [63:0] t, input logic [31:0] low);
		return {t[63:32] + 32'(low < t[31:0]), low};
	endfunction

	task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input bit host, input logic [11:0] a, input logic [63:0] d, input int len);
		for (int i = 0; i < len; i++) begin
			if (host) u_host.wr(a + 12'(i), d[8*i +: 8]);
			else u_net.wr(a + 12'(i), d[8*i +: 8]);
		end
	endtask

	task automatic rd(input bit host, input logic [11:0] a, input int len, output logic [63:0] d);
		logic [7:0] b;
		d = '0;
		for (int i = 0; i < len; i++) begin
			if (host) u_host.rd(a + 12'(i), b);
			else u_net.rd(a + 12'(i), b);
			d[8*i +: 8] = b;
		end
	endtask

	task automatic frame();
		@(posedge clock);
		frame_end <= 1'b1;
		@(posedge clock);
		frame_end <= 1'b0;
		repeat (3) @(posedge clock);
		#1;
	endtask

	task automatic nv(input logic [15:0] a, input logic [15:0] d);
		@(posedge clock);
		nv_load <= 1'b1;
		nv_addr <= a;
		nv_data <= d;
		@(posedge clock);
		nv_load <= 1'b0;
	endtask

	task automatic wait_rise(input int ch, output logic [63:0] t);
		int r;
		r = rises[ch];
		for (int i = 0; i < 3000 && rises[ch] == r; i++) begin
			@(posedge clock);
			#1;
		end
		check("sync rise seen", 1, 64'(rises[ch] != r));
		t = system_time;
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		system_time = 64'h0000_0002_0000_0000;
		frame_end = 1'b0;
		write_ack_enable = 1'b0;
		nv_load = 1'b0;
		nv_addr = 16'h0000;
		nv_data = 16'h0000;
		err_total = 0;
		total_checks = 0;
		cycles = 0;
		seed = 8'h3e;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		for (int i = 0; i < 7; i++) begin
			rd(0, offs[i], lens[i], v);
			check("reset value", 0, v);
		end
		nv(16'h0001, 16'h0009);
		nv(sync_out_pkg::nv_pulse_length_addr, 16'h0004);
		wr(0, sync_out_pkg::pulse_length_off, 16'hffff, 2);
		rd(0, sync_out_pkg::pulse_length_off, 2, v);
		check("pulse length", 16'h0004, v);
		wr(1, sync_out_pkg::activation_off, 8'h06, 1);
		rd(0, sync_out_pkg::activation_off, 1, v);
		check("host write refused", 8'h00, v);
		wr(0, sync_out_pkg::cyclic_control_off, 8'h01, 1);
		wr(0, sync_out_pkg::activation_off, 8'h06, 1);
		wr(1, sync_out_pkg::activation_off, 8'h84, 1);
		rd(1, sync_out_pkg::activation_off, 1, v);
		check("host owned activation", 8'h04, v);
		wr(1, sync_out_pkg::activation_off, 8'h00, 1);
		wr(0, sync_out_pkg::cyclic_control_off, 8'h00, 1);
		// cyclic run from a 32-bit start time
		wr(0, sync_out_pkg::first_cycle_off, 32'h0000_03e8, 4);
		wr(0, sync_out_pkg::second_shift_off, 32'h0000_00c8, 4);
		seed = lfsr(seed);
		wr(0, sync_out_pkg::activation_off, 8'h1e, 1);
		now = system_time;
		start = extend(now, now[31:0] + 32'h0000_07d0 + 32'(seed[5:0]) * 32'h0000_000a);
		wr(0, sync_out_pkg::start_time_off, start, 4);
		frame();
		rd(0, sync_out_pkg::activation_off, 1, v);
		check("auto activation", 8'h1f, v);
		rd(0, sync_out_pkg::activation_status_off, 1, v);
		check("first pulses pending", 8'h03, v);
		rd(0, sync_out_pkg::start_time_off, 8, v);
		check("extended start", start, v);
		wait_rise(0, t1);
		check("first pulse at start", 1, 64'((t1 - start) <= slack));
		wait_rise(1, t2);
		check("first pulse width", 4, 64'(width[0]));
		check("second pulse shift", 200, t2 - t1);
		wait_rise(0, t3);
		check("cycle spacing", 1000, t3 - t1);
		wait_rise(1, t2);
		wr(0, sync_out_pkg::start_time_off, 8'h00, 1);
		rd(0, sync_out_pkg::start_time_off, 8, v);
		check("next first time", start + 2000, v);
		rd(0, sync_out_pkg::next_second_off, 8, v);
		check("next second time", start + 2200, v);
		n = rises[0] + rises[1];
		wr(0, sync_out_pkg::activation_off, 8'h9f, 1);
		repeat (8) @(posedge clock);
		#1;
		check("debug pulses", n + 2, rises[0] + rises[1]);
		wr(0, sync_out_pkg::activation_off, 8'h00, 1);
		n = rises[0] + rises[1];
		repeat (250) @(posedge clock);
		#1;
		check("quiet when off", n, rises[0] + rises[1]);
		// acknowledge mode: read ack on the first channel, write ack on the second
		nv(sync_out_pkg::nv_pulse_length_addr, 16'h0000);
		wr(0, sync_out_pkg::first_cycle_off, 32'h0000_0000, 4);
		for (int m = 0; m < 2; m++) begin
			write_ack_enable <= m[0];
			n = rises[1 - m];
			wr(0, sync_out_pkg::activation_off, m ? 8'h0c : 8'h0a, 1);
			start = system_time + 64'h0000_0000_0000_0258;
			wr(0, sync_out_pkg::start_time_off, start, 8);
			frame();
			wait_rise(m, t1);
			repeat (20) @(posedge clock);
			#1;
			check("held until ack", 1, outs[m]);
			k = clears[m];
			if (m == 1) wr(1, sync_out_pkg::second_status_off, 8'h00, 1);
			else rd(1, sync_out_pkg::first_status_off, 1, v);
			repeat (3) @(posedge clock);
			#1;
			check("event clear", k + 1, clears[m]);
			check("released by ack", 0, outs[m]);
			check("disabled channel silent", n, rises[1 - m]);
			wr(0, sync_out_pkg::activation_off, 8'h00, 1);
		end
		// out-of-near-future start fires at once, long and short window
		write_ack_enable <= 1'b0;
		for (int m = 0; m < 2; m++) begin
			wr(0, sync_out_pkg::activation_off, m ? 8'h6a : 8'h2a, 1);
			now = system_time;
			start = m ? now + 64'h0000_0001_0000_0000 : now - 64'h0000_0000_0000_03e8;
			wr(0, sync_out_pkg::start_time_off, start, 8);
			frame();
			wait_rise(0, t1);
			check("immediate pulse", 1, 64'((t1 - now) <= 64'h0000_0000_0000_01f4));
			rd(0, sync_out_pkg::activation_status_off, 1, v);
			check("out of near future", 1, v[2]);
			wr(0, sync_out_pkg::activation_off, 8'h00, 1);
			rd(1, sync_out_pkg::first_status_off, 1, v);
			repeat (3) @(posedge clock);
		end
		results();
	end
endmodule

// file: dv/reg_port_model.sv
`timescale 1ns/1ps
// byte-wide register master for one side of the unit
module reg_port_model (
	input  wire logic              clock,
	input  wire logic [7:0]        rdata,
	output sync_out_pkg::reg_req_t req
);
	initial req = '{write: 1'b0, read: 1'b0, addr: 12'h000, wdata: 8'h00};

	// idle fields carry inverted junk so a stale address never looks valid
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clock);
		req <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
		@(posedge clock);
		req <= '{write: 1'b0, read: 1'b0, addr: ~a, wdata: ~d};
	endtask

	task automatic rd(input logic [11:0] a, output logic [7:0] d);
		@(posedge clock);
		req <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clock);
		req <= '{write: 1'b0, read: 1'b0, addr: ~a, wdata: 8'hff};
		#1;
		d = rdata;
	endtask
endmodule

// file: rtl/near_future_check.sv
`timescale 1ns/1ps
// decides whether a start time lies within the near-future window
module near_future_check (
	input  wire logic [63:0] system_time,
	input  wire logic [63:0] start_time,
	input  wire logic        short_window,
	output logic             out_of_near
);
	logic [63:0] ahead;

	always_comb begin
		ahead = start_time - system_time;
		if (short_window) begin
			out_of_near = ahead >= sync_out_pkg::near_short_ns;
		end else begin
			out_of_near = ahead >= sync_out_pkg::near_half_ns;
		end
	end
endmodule

// file: rtl/pulse_stretch.sv
`timescale 1ns/1ps
// holds one sync output for a pulse length, or until acknowledged
module pulse_stretch #(
	parameter int unit_cycles = 1
) (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        fire,
	input  wire logic        ack,
	input  wire logic [15:0] length,
	output logic             level
);
	logic [31:0] count_q;

	always_ff @(posedge clock) begin
		if (rst) begin
			level   <= 1'b0;
			count_q <= 32'h0000_0000;
		end else if (fire) begin
			level   <= 1'b1;
			count_q <= 32'(length) * 32'(unit_cycles);
		end else if (length == 16'h0000) begin
			if (ack) begin
				level <= 1'b0;
			end
		end else if (level) begin
			if (count_q <= 32'h0000_0001) begin
				level <= 1'b0;
			end
			count_q <= count_q - 32'h0000_0001;
		end
	end

	a_ack_holds: assert property (@(posedge clock) disable iff (rst)
		level && length == 16'h0000 && !ack && !fire |=> level)
		else $error("ack mode output dropped without ack");
	a_one_unit_len: assert property (@(posedge clock) disable iff (rst)
		fire && length == 16'h0001 |=> level ##1 !level || fire)
		else $error("pulse length one unit wrong");
endmodule

// file: rtl/sync_out_pkg.sv
package sync_out_pkg;
	// byte offsets of the register map, and the non-volatile pulse length address
	localparam logic [11:0] cyclic_control_off     = 12'h0980;
	localparam logic [11:0] activation_off         = 12'h0981;
	localparam logic [11:0] pulse_length_off       = 12'h0982;
	localparam logic [11:0] activation_status_off  = 12'h0984;
	localparam logic [11:0] first_status_off       = 12'h098e;
	localparam logic [11:0] second_status_off      = 12'h098f;
	localparam logic [11:0] start_time_off         = 12'h0990;
	localparam logic [11:0] next_second_off        = 12'h0998;
	localparam logic [11:0] first_cycle_off        = 12'h09a0;
	localparam logic [11:0] second_shift_off       = 12'h09a4;
	localparam logic [15:0] nv_pulse_length_addr   = 16'h0002;

	// activation register fields, then the status and control bit positions
	localparam int act_unit_bit    = 0;
	localparam int act_first_bit   = 1;
	localparam int act_second_bit  = 2;
	localparam int act_auto_bit    = 3;
	localparam int act_extend_bit  = 4;
	localparam int act_check_bit   = 5;
	localparam int act_near_bit    = 6;
	localparam int act_debug_bit   = 7;
	localparam int stat_out_of_near_bit = 2;
	localparam int ctrl_owner_bit  = 0;

	localparam logic [7:0]  activation_reset  = 8'h00;
	localparam logic [15:0] pulse_length_reset = 16'h0000;
	localparam logic [63:0] time_reset        = 64'h0000_0000_0000_0000;
	localparam logic [31:0] cycle_reset       = 32'h0000_0000;

	// near-future windows, in ns
	localparam logic [63:0] near_short_ns = 64'h0000_0000_8000_0000;
	localparam logic [63:0] near_half_ns  = 64'h8000_0000_0000_0000;

	// one pulse-length unit in ns, and the clock period
	localparam int pulse_unit_ns  = 10;
	localparam int clock_period_ns = 10;
	localparam int pulse_unit_cycles = (pulse_unit_ns + clock_period_ns - 1) / clock_period_ns;

	typedef struct packed {
		logic        write;
		logic        read;
		logic [11:0] addr;
		logic [7:0]  wdata;
	} reg_req_t;

	typedef enum logic {
		owner_network,
		owner_local
	} owner_t;
endpackage

// file: rtl/sync_output_unit.sv
`timescale 1ns/1ps
module sync_output_unit #(
	parameter int unit_cycles = sync_out_pkg::pulse_unit_cycles
) (
	input  wire logic                   clock,
	input  wire logic                   rst,
	input  wire logic [63:0]            system_time,
	input  wire sync_out_pkg::reg_req_t net_req,
	input  wire sync_out_pkg::reg_req_t host_req,
	input  wire logic                   frame_end,
	input  wire logic                   write_ack_enable,
	input  wire logic                   nv_load,
	input  wire logic [15:0]            nv_addr,
	input  wire logic [15:0]            nv_data,
	output logic [7:0]                  net_rdata,
	output logic [7:0]                  host_rdata,
	output logic                        first_sync_pulse,
	output logic                        second_sync_pulse,
	output logic                        first_event_clear,
	output logic                        second_event_clear
);

	logic [7:0]  control_q;
	logic [7:0]  act_q;
	logic [15:0] pulse_len_q;
	logic [2:0]  status_q;
	logic [63:0] start_q;
	logic [63:0] next_first_q;
	logic [63:0] next_second_q;
	logic [31:0] first_cycle_q;
	logic [31:0] second_shift_q;
	logic [7:0]  low_written_q;
	logic [7:0]  high_written_q;
	logic        arm_q;
	logic        first_fire;
	logic        second_fire;
	logic        first_ack;
	logic        second_ack;
	logic        out_of_near;
	logic        owner_local;
	sync_out_pkg::reg_req_t own_req;
	logic [7:0]  net_mux;
	logic [7:0]  host_mux;

	////////////////////////////////////////////////////////////////////////////////
	// register read decode
	function automatic logic [7:0] read_byte(input logic [11:0] a, input logic [7:0] ctl,
		input logic [7:0] act, input logic [15:0] len, input logic [2:0] st,
		input logic [63:0] nf, input logic [63:0] ns, input logic [31:0] fc,
		input logic [31:0] sc);
		logic [7:0] r;
		r = 8'h00;
		if (a == sync_out_pkg::cyclic_control_off) r = ctl;
		else if (a == sync_out_pkg::activation_off) r = {1'b0, act[6:0]};
		else if (a == sync_out_pkg::pulse_length_off) r = len[7:0];
		else if (a == sync_out_pkg::pulse_length_off + 12'h001) r = len[15:8];
		else if (a == sync_out_pkg::activation_status_off) r = {5'h00, st};
		else if (a == sync_out_pkg::first_status_off) r = {7'h00, st[0]};
		else if (a == sync_out_pkg::second_status_off) r = {7'h00, st[1]};
		else if (a[11:3] == sync_out_pkg::start_time_off[11:3]) r = nf[a[2:0]*8 +: 8];
		else if (a[11:3] == sync_out_pkg::next_second_off[11:3]) r = ns[a[2:0]*8 +: 8];
		else if (a[11:2] == sync_out_pkg::first_cycle_off[11:2]) r = fc[a[1:0]*8 +: 8];
		else if (a[11:2] == sync_out_pkg::second_shift_off[11:2]) r = sc[a[1:0]*8 +: 8];
		return r;
	endfunction

	assign owner_local = control_q[sync_out_pkg::ctrl_owner_bit];
	assign own_req     = owner_local ? host_req : net_req;

	always_comb begin
		net_mux  = read_byte(net_req.addr, control_q, act_q, pulse_len_q, status_q,
			next_first_q, next_second_q, first_cycle_q, second_shift_q);
		host_mux = read_byte(host_req.addr, control_q, act_q, pulse_len_q, status_q,
			next_first_q, next_second_q, first_cycle_q, second_shift_q);
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			net_rdata  <= 8'h00;
			host_rdata <= 8'h00;
		end else begin
			net_rdata  <= net_req.read ? net_mux : 8'h00;
			host_rdata <= host_req.read ? host_mux : 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// ownership register, network side only
	always_ff @(posedge clock) begin
		if (rst) begin
			control_q <= 8'h00;
		end else if (net_req.write && net_req.addr == sync_out_pkg::cyclic_control_off) begin
			control_q <= net_req.wdata & 8'h31;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pulse length from non-volatile configuration
	always_ff @(posedge clock) begin
		if (rst) begin
			pulse_len_q <= sync_out_pkg::pulse_length_reset;
		end else if (nv_load && nv_addr == sync_out_pkg::nv_pulse_length_addr) begin
			pulse_len_q <= nv_data;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// cycle time and second-channel shift
	always_ff @(posedge clock) begin
		if (rst) begin
			first_cycle_q  <= sync_out_pkg::cycle_reset;
			second_shift_q <= sync_out_pkg::cycle_reset;
		end else if (own_req.write) begin
			if (own_req.addr[11:2] == sync_out_pkg::first_cycle_off[11:2]) begin
				first_cycle_q[own_req.addr[1:0]*8 +: 8] <= own_req.wdata;
			end
			if (own_req.addr[11:2] == sync_out_pkg::second_shift_off[11:2]) begin
				second_shift_q[own_req.addr[1:0]*8 +: 8] <= own_req.wdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// start time: byte writes tracked within a frame
	logic start_write;
	assign start_write = own_req.write && !act_q[sync_out_pkg::act_unit_bit]
		&& own_req.addr[11:3] == sync_out_pkg::start_time_off[11:3];

	always_ff @(posedge clock) begin
		if (rst) begin
			start_q        <= sync_out_pkg::time_reset;
			low_written_q  <= 8'h00;
			high_written_q <= 8'h00;
			arm_q          <= 1'b0;
		end else begin
			arm_q <= 1'b0;
			if (start_write) begin
				start_q[own_req.addr[2:0]*8 +: 8] <= own_req.wdata;
				if (own_req.addr[2]) high_written_q[own_req.addr[2:0]] <= 1'b1;
				else low_written_q[own_req.addr[2:0]] <= 1'b1;
			end
			if (frame_end && low_written_q != 8'h00) begin
				// extend the upper half only if it was left alone in this frame
				if (act_q[sync_out_pkg::act_extend_bit] && high_written_q == 8'h00) begin
					start_q[63:32] <= (start_q[31:0] < system_time[31:0])
						? system_time[63:32] + 32'h0000_0001 : system_time[63:32];
				end
				arm_q          <= 1'b1;
				low_written_q  <= 8'h00;
				high_written_q <= 8'h00;
			end else if (frame_end) begin
				arm_q          <= high_written_q != 8'h00;
				high_written_q <= 8'h00;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// activation register and status
	near_future_check u_check (
		.system_time (system_time),
		.start_time  (start_q),
		.short_window(act_q[sync_out_pkg::act_near_bit]),
		.out_of_near (out_of_near)
	);

	logic act_write;
	assign act_write = own_req.write && own_req.addr == sync_out_pkg::activation_off;

	always_ff @(posedge clock) begin
		if (rst) begin
			act_q <= sync_out_pkg::activation_reset;
		end else begin
			act_q[sync_out_pkg::act_debug_bit] <= 1'b0;
			if (act_write) begin
				act_q <= own_req.wdata;
			end else if (arm_q && act_q[sync_out_pkg::act_auto_bit]) begin
				act_q[sync_out_pkg::act_unit_bit] <= 1'b1;
			end
		end
	end

	logic unit_on;
	logic unit_rise;
	logic unit_on_q;
	assign unit_on = act_q[sync_out_pkg::act_unit_bit];
	assign unit_rise = unit_on && !unit_on_q;

	////////////////////////////////////////////////////////////////////////////////
	// pulse scheduling
	logic debug;
	assign debug = act_q[sync_out_pkg::act_debug_bit];
	// in the unit-rise cycle only a debug pulse can fire; scheduled firing starts a cycle later
	assign first_fire = unit_on && act_q[sync_out_pkg::act_first_bit]
		&& ((!unit_rise && system_time >= next_first_q) || debug);
	assign second_fire = unit_on && act_q[sync_out_pkg::act_second_bit]
		&& ((!unit_rise && system_time >= next_second_q) || debug);

	always_ff @(posedge clock) begin
		if (rst) begin
			unit_on_q     <= 1'b0;
			status_q      <= 3'b000;
			next_first_q  <= sync_out_pkg::time_reset;
			next_second_q <= sync_out_pkg::time_reset;
		end else begin
			unit_on_q <= unit_on;
			if (!unit_on) begin
				status_q[1:0] <= 2'b00;
				next_first_q  <= start_q;
				next_second_q <= start_q + 64'(second_shift_q);
			end else if (unit_rise) begin
				status_q[sync_out_pkg::stat_out_of_near_bit] <= out_of_near;
				status_q[0] <= act_q[sync_out_pkg::act_first_bit];
				status_q[1] <= act_q[sync_out_pkg::act_second_bit];
				if (act_q[sync_out_pkg::act_check_bit] && out_of_near) begin
					next_first_q  <= system_time;
					next_second_q <= system_time + 64'(second_shift_q);
				end
			end else begin
				// each channel steps its own schedule, so no second pulse is skipped
				if (first_fire && !debug) begin
					status_q[0] <= 1'b0;
					if (first_cycle_q != 32'h0000_0000) begin
						next_first_q <= next_first_q + 64'(first_cycle_q);
					end else begin
						next_first_q <= 64'hffff_ffff_ffff_ffff;
					end
				end
				if (second_fire && !debug) begin
					status_q[1] <= 1'b0;
					if (first_cycle_q != 32'h0000_0000) begin
						next_second_q <= next_second_q + 64'(first_cycle_q);
					end else begin
						next_second_q <= 64'hffff_ffff_ffff_ffff;
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// acknowledge of channel status from the local host port
	function automatic logic host_ack(input sync_out_pkg::reg_req_t r, input logic [11:0] a,
		input logic wack);
		return (r.addr == a) && (wack ? r.write : r.read);
	endfunction

	assign first_ack  = host_ack(host_req, sync_out_pkg::first_status_off, write_ack_enable);
	assign second_ack = host_ack(host_req, sync_out_pkg::second_status_off, write_ack_enable);

	always_ff @(posedge clock) begin
		if (rst) begin
			first_event_clear  <= 1'b0;
			second_event_clear <= 1'b0;
		end else begin
			first_event_clear  <= first_ack;
			second_event_clear <= second_ack;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// output stages
	pulse_stretch #(.unit_cycles(unit_cycles)) u_first (
		.clock (clock),
		.rst   (rst),
		.fire  (first_fire),
		.ack   (first_ack),
		.length(pulse_len_q),
		.level (first_sync_pulse)
	);

	pulse_stretch #(.unit_cycles(unit_cycles)) u_second (
		.clock (clock),
		.rst   (rst),
		.fire  (second_fire),
		.ack   (second_ack),
		.length(pulse_len_q),
		.level (second_sync_pulse)
	);

	////////////////////////////////////////////////////////////////////////////////
	// checks
	a_unit_off_idle: assert property (@(posedge clock) disable iff (rst)
		!unit_on |-> !first_fire && !second_fire)
		else $error("pulse fired while unit inactive");
	a_chan_gate: assert property (@(posedge clock) disable iff (rst)
		first_fire |-> act_q[sync_out_pkg::act_first_bit])
		else $error("first pulse fired while channel off");
	a_debug_clear: assert property (@(posedge clock) disable iff (rst)
		debug |=> !debug || $past(act_write))
		else $error("debug bit did not self clear");
	a_start_locked: assert property (@(posedge clock) disable iff (rst)
		$past(unit_on) && unit_on && !$past(frame_end) |-> $stable(start_q))
		else $error("start time changed while active");
	a_auto_act: assert property (@(posedge clock) disable iff (rst)
		arm_q && act_q[sync_out_pkg::act_auto_bit] && !act_write |=> unit_on)
		else $error("auto activation missed");
	a_ev_clear: assert property (@(posedge clock) disable iff (rst)
		first_ack |=> first_event_clear)
		else $error("event request bit 2 not cleared");
	a_ev2_clear: assert property (@(posedge clock) disable iff (rst)
		second_ack |=> second_event_clear)
		else $error("event request bit 3 not cleared");
	a_near_record: assert property (@(posedge clock) disable iff (rst)
		unit_rise |=> status_q[2] == $past(out_of_near))
		else $error("near future result not recorded");
	a_owner_gate: assert property (@(posedge clock) disable iff (rst)
		owner_local && net_req.write && !host_req.write |=> $stable(first_cycle_q))
		else $error("non-owner write accepted");
	a_first_step: assert property (@(posedge clock) disable iff (rst)
		first_fire && !debug && first_cycle_q != 32'h0000_0000
		|=> next_first_q == $past(next_first_q) + 64'($past(first_cycle_q)))
		else $error("first schedule did not advance");
	a_second_step: assert property (@(posedge clock) disable iff (rst)
		second_fire && !debug && first_cycle_q != 32'h0000_0000
		|=> next_second_q == $past(next_second_q) + 64'($past(first_cycle_q)))
		else $error("second schedule did not advance");
	c_first_pulse: cover property (@(posedge clock) first_fire);
	c_second_pulse: cover property (@(posedge clock) second_fire);
	c_auto: cover property (@(posedge clock) arm_q && act_q[sync_out_pkg::act_auto_bit]);
	c_out_near: cover property (@(posedge clock) unit_rise && out_of_near);
endmodule
